// File: src/aocs_pkg.sv
// constants, types and register map for the analogue output channel supervisor
// Overview of operation
// R1: per-channel range, default 0-10 V
// R2: one unit data format, default offset binary
// R3: upper limit check raises channel error
// R4: lower limit check raises channel error
// R5: scaled high bound, -32766..32767, default 1000
// R6: scaled low bound, -32767..32766, default 0
// R7: comm error: fault value or hold
// R8: comm idle: idle value or hold
// R9: substitution only under terminal priority
// R10: supply short raises unit error
// R11: host keeps limits inside range window
// R12: host keeps substitutes inside range span
// R13: host reviews limits after range change
// R14: idle may never occur on some controllers
// R15: error flags held until condition clears
package aocs_pkg;
	localparam int NUM_CH = 4; // output channels on the unit
	localparam int ADDR_W = 8;
	// range codes
	localparam logic [2:0] RANGE_0_10V = 3'h0;
	localparam logic [2:0] RANGE_0_5V = 3'h1;
	localparam logic [2:0] RANGE_1_5V = 3'h2;
	localparam logic [2:0] RANGE_0_20MA = 3'h3;
	localparam logic [2:0] RANGE_4_20MA = 3'h4;
	// data format codes
	localparam logic [1:0] FMT_OFFSET = 2'h0;
	localparam logic [1:0] FMT_SIGNMAG = 2'h1;
	localparam logic [1:0] FMT_TWOS = 2'h2;
	localparam logic [1:0] FMT_SCALED = 2'h3;
	// scaled bound limits and defaults
	localparam logic signed [15:0] HIGH_MIN = -16'sd32766;
	localparam logic signed [15:0] HIGH_MAX = 16'sd32767;
	localparam logic signed [15:0] HIGH_DEF = 16'sd1000;
	localparam logic signed [15:0] LOW_MIN = -16'sd32767;
	localparam logic signed [15:0] LOW_MAX = 16'sd32766;
	localparam logic signed [15:0] LOW_DEF = 16'sh0000;
	// unit registers
	localparam logic [ADDR_W-1:0] REG_UNIT_CTRL = 8'h00; // [0]short mon [2:1]fmt [3]term prio
	localparam logic [ADDR_W-1:0] REG_COMM = 8'h04; // [0]comm error [1]comm idle
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_DIAG = 8'h10; // live error flags
	// per-channel block: base + ch*CH_STRIDE
	localparam logic [ADDR_W-1:0] CH_BASE = 8'h40;
	localparam int CH_STRIDE = 32;
	localparam logic [4:0] CH_CTRL = 5'h00; // [2:0]range [3]hi en [4]lo en [5]fault en [6]idle en
	localparam logic [4:0] CH_HIGH = 5'h04;
	localparam logic [4:0] CH_LOW = 5'h08;
	localparam logic [4:0] CH_FAULT = 5'h0C;
	localparam logic [4:0] CH_IDLE = 5'h10;
	localparam logic [4:0] CH_VALUE = 5'h14; // demanded value from controller
	localparam logic [4:0] CH_OUT = 5'h18; // applied output, read only
	localparam int CTL_SHORT = 0;
	localparam int CTL_TERM = 3;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001; // short monitor on
	// per-channel settings
	typedef struct packed {
		logic [2:0] range;
		logic highEn;
		logic lowEn;
		logic faultEn;
		logic idleEn;
		logic signed [15:0] highBound;
		logic signed [15:0] lowBound;
		logic signed [15:0] faultValue;
		logic signed [15:0] idleValue;
		logic signed [15:0] demand;
		logic signed [15:0] applied;
	} aocs_chan_type;
	// register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} aocs_bus_type;
	typedef enum logic [1:0] {COMM_RUN, COMM_FAULT, COMM_IDLE} aocs_comm_type;
endpackage

// File: src/aocs_supervisor.sv
// analogue output channel supervisor: settings, limit checks, substitution
`timescale 1ns/1ps
`default_nettype none
module aocs_supervisor import aocs_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire aocs_bus_type bus,
	input wire logic supplyShort, // live short detect on output supply
	output logic [31:0] rdata,
	output logic irq,
	output logic [NUM_CH*16-1:0] chanOut, // applied output codes
	output logic [1:0] dataFormat,
	output logic [NUM_CH*3-1:0] chanRange
);
	////////////////////////////////////////////////////////////////
	// state: one struct, next value built combinationally
	typedef struct packed {
		aocs_chan_type [NUM_CH-1:0] ch;
		logic shortMonEn; // supply_short_monitor_enable
		logic [1:0] fmt;
		logic termPrio; // hold/clear priority set to terminal
		logic commError;
		logic commIdle;
		logic [NUM_CH*2:0] stat; // sticky: {short, lo[n], hi[n]}
		logic [NUM_CH*2:0] mask;
		logic [NUM_CH*2:0] diag; // live flags
		logic [31:0] rdata;
		logic irq;
	} aocs_state_type;

	aocs_state_type s_q, s_d;
	logic [NUM_CH-1:0] hiErr, loErr; // combinational check results
	logic [NUM_CH*2:0] events;
	aocs_comm_type commMode;

	////////////////////////////////////////////////////////////////
	// communication mode; fault takes priority over idle
	always_comb begin
		if (s_q.commError) begin
			commMode = COMM_FAULT;
		end else if (s_q.commIdle) begin
			commMode = COMM_IDLE; // may never occur on some controllers [R14]
		end else begin
			commMode = COMM_RUN;
		end
	end

	// per-channel limit comparisons on the applied output
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gChk
			assign hiErr[g] = s_q.ch[g].highEn && (s_q.ch[g].applied > s_q.ch[g].highBound); // [R3] [R5]
			assign loErr[g] = s_q.ch[g].lowEn && (s_q.ch[g].applied < s_q.ch[g].lowBound); // [R4] [R6]
		end
	endgenerate
	assign events = {s_q.shortMonEn & supplyShort, loErr, hiErr}; // [R10]

	////////////////////////////////////////////////////////////////
	// next state: bus writes, substitution, flags, read data
	always_comb begin
		int idx;
		logic [4:0] off;
		logic hit;
		logic signed [15:0] wv;
		idx = 0;
		off = 5'h00;
		hit = 1'b0;
		wv = bus.wdata[15:0];
		s_d = s_q;
		s_d.rdata = 32'h0000_0000;
		if (bus.addr >= CH_BASE) begin
			idx = int'(bus.addr - CH_BASE) / CH_STRIDE;
			off = 5'((bus.addr - CH_BASE) % CH_STRIDE);
			hit = idx < NUM_CH;
		end
		// register writes
		if (bus.wr) begin
			unique case (bus.addr)
				REG_UNIT_CTRL: begin
					s_d.shortMonEn = bus.wdata[CTL_SHORT];
					s_d.fmt = bus.wdata[2:1]; // one format for the unit [R2]
					s_d.termPrio = bus.wdata[CTL_TERM];
				end
				REG_COMM: begin
					s_d.commError = bus.wdata[0];
					s_d.commIdle = bus.wdata[1];
				end
				REG_IRQ_MASK: s_d.mask = bus.wdata[NUM_CH*2:0];
				default: begin
					if (hit) begin
						unique case (off)
							CH_CTRL: begin
								// unknown range codes are refused, range kept [R1]
								if (bus.wdata[2:0] <= RANGE_4_20MA) begin
									s_d.ch[idx].range = bus.wdata[2:0];
								end
								s_d.ch[idx].highEn = bus.wdata[3];
								s_d.ch[idx].lowEn = bus.wdata[4];
								s_d.ch[idx].faultEn = bus.wdata[5];
								s_d.ch[idx].idleEn = bus.wdata[6];
							end
							CH_HIGH: begin
								// saturate: -32768 is not an accepted bound [R5]
								s_d.ch[idx].highBound = (wv < HIGH_MIN) ? HIGH_MIN : wv;
							end
							CH_LOW: begin
								// 32767 is not an accepted low bound [R6]
								s_d.ch[idx].lowBound = (wv > LOW_MAX) ? LOW_MAX :
									((wv < LOW_MIN) ? LOW_MIN : wv);
							end
							CH_FAULT: s_d.ch[idx].faultValue = wv;
							CH_IDLE: s_d.ch[idx].idleValue = wv;
							CH_VALUE: s_d.ch[idx].demand = wv;
							default: ;
						endcase
					end
				end
			endcase
		end
		// output selection per channel
		for (int i = 0; i < NUM_CH; i++) begin
			unique case (commMode)
				COMM_RUN: s_d.ch[i].applied = s_q.ch[i].demand;
				COMM_FAULT: begin
					// substitution only under terminal priority, else hold [R7] [R9]
					if (s_q.termPrio && s_q.ch[i].faultEn) begin
						s_d.ch[i].applied = s_q.ch[i].faultValue;
					end
				end
				COMM_IDLE: begin
					if (s_q.termPrio && s_q.ch[i].idleEn) begin // [R8] [R9]
						s_d.ch[i].applied = s_q.ch[i].idleValue;
					end
				end
				default: ;
			endcase
		end
		// live diagnostics follow the condition [R15]
		s_d.diag = events;
		// sticky status: set beats a write-one clear
		if (bus.wr && bus.addr == REG_IRQ_STAT) begin
			s_d.stat = s_q.stat & ~bus.wdata[NUM_CH*2:0];
		end
		s_d.stat = s_d.stat | events;
		s_d.irq = |(s_d.stat & s_d.mask);
		// read data, one cycle after the strobe
		if (bus.rd) begin
			unique case (bus.addr)
				REG_UNIT_CTRL: s_d.rdata = {28'h0000000, s_q.termPrio, s_q.fmt, s_q.shortMonEn};
				REG_COMM: s_d.rdata = {30'h0, s_q.commIdle, s_q.commError};
				REG_IRQ_STAT: s_d.rdata = 32'(s_q.stat);
				REG_IRQ_MASK: s_d.rdata = 32'(s_q.mask);
				REG_DIAG: s_d.rdata = 32'(s_q.diag);
				default: begin
					if (hit) begin
						unique case (off)
							CH_CTRL: s_d.rdata = {25'h0, s_q.ch[idx].idleEn,
								s_q.ch[idx].faultEn, s_q.ch[idx].lowEn,
								s_q.ch[idx].highEn, s_q.ch[idx].range};
							CH_HIGH: s_d.rdata = 32'(s_q.ch[idx].highBound);
							CH_LOW: s_d.rdata = 32'(s_q.ch[idx].lowBound);
							CH_FAULT: s_d.rdata = 32'(s_q.ch[idx].faultValue);
							CH_IDLE: s_d.rdata = 32'(s_q.ch[idx].idleValue);
							CH_VALUE: s_d.rdata = 32'(s_q.ch[idx].demand);
							CH_OUT: s_d.rdata = 32'(s_q.ch[idx].applied);
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// state register with documented defaults
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				s_q.ch[i].range <= RANGE_0_10V; // [R1]
				s_q.ch[i].highBound <= HIGH_DEF; // [R5]
				s_q.ch[i].lowBound <= LOW_DEF; // [R6]
			end
			s_q.shortMonEn <= CTRL_RST[CTL_SHORT]; // [R10]
			s_q.fmt <= FMT_OFFSET; // [R2]
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state flops
	assign rdata = s_q.rdata;
	assign irq = s_q.irq;
	assign dataFormat = s_q.fmt;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gOut
			assign chanOut[g*16 +: 16] = s_q.ch[g].applied;
			assign chanRange[g*3 +: 3] = s_q.ch[g].range;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_high_flag_set: assert property (s_q.ch[0].highEn && s_q.ch[0].applied > s_q.ch[0].highBound
		|=> s_q.diag[0] && s_q.stat[0]) else $error("upper limit error missed"); // [R3]
	a_low_flag_set: assert property (s_q.ch[0].lowEn && s_q.ch[0].applied < s_q.ch[0].lowBound
		|=> s_q.diag[NUM_CH] && s_q.stat[NUM_CH]) else $error("lower limit error missed"); // [R4]
	a_high_disabled: assert property (!s_q.ch[1].highEn |=> !s_q.diag[1])
		else $error("upper flag without enable"); // [R3]
	a_fault_subst: assert property (commMode == COMM_FAULT && s_q.termPrio && s_q.ch[2].faultEn
		|=> s_q.ch[2].applied == $past(s_q.ch[2].faultValue)) else $error("fault value not driven"); // [R7]
	a_hold_no_prio: assert property (commMode != COMM_RUN && !s_q.termPrio
		|=> $stable(s_q.ch[0].applied)) else $error("output changed without priority"); // [R9]
	a_idle_subst: assert property (commMode == COMM_IDLE && s_q.termPrio && s_q.ch[2].idleEn
		|=> s_q.ch[2].applied == $past(s_q.ch[2].idleValue)) else $error("idle value not driven"); // [R8]
	a_short_flag: assert property (s_q.shortMonEn && supplyShort |=> s_q.diag[NUM_CH*2] ##1 irq
		|| !s_q.mask[NUM_CH*2]) else $error("short error missed"); // [R10]
	a_high_range: assert property (s_q.ch[0].highBound >= HIGH_MIN)
		else $error("high bound below range"); // [R5]
	a_low_range: assert property (s_q.ch[0].lowBound <= LOW_MAX && s_q.ch[0].lowBound >= LOW_MIN)
		else $error("low bound out of range"); // [R6]
	a_diag_clears: assert property (!events[0] |=> !s_q.diag[0])
		else $error("flag held after clear"); // [R15]
	a_sticky_wins: assert property (events[1] |=> s_q.stat[1])
		else $error("event lost under clear"); // [R15]

	c_fault: cover property (commMode == COMM_FAULT && s_q.termPrio ##1 s_q.ch[2].faultEn);
	c_idle: cover property (commMode == COMM_IDLE && s_q.termPrio);
	c_irq: cover property (!irq ##1 irq);
	c_scaled: cover property (s_q.fmt == FMT_SCALED && s_q.diag[0]);
endmodule
`default_nettype wire

// File: test/aocs_plc_model.sv
// controller model that writes and reads the unit settings
`timescale 1ns/1ps
`default_nettype none
module aocs_plc_model import aocs_pkg::*; (
	input wire logic clk_sys,
	input wire logic [31:0] rdata,
	output aocs_bus_type bus
);
	// both strobes idle low from time zero
	initial begin
		bus = '0;
	end
	////////////////////////////////////////////////////////////////
	// one write cycle, then quiet cycles so the effect has landed
	// callers hand over limits and substitutes that suit the range, apart from the out-of-range bounds t_limits writes to test saturation
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus <= '0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	// read strobe; data stands only in the following cycle
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus <= '0;
		#1;
		d = rdata;
		@(posedge clk_sys);
		// step off the edge so callers never sample outputs as they launch
		#1;
	endtask
endmodule
`default_nettype wire

// File: test/analog_output_channel_supervisor_bench.sv
// self-checking bench for the analogue output channel supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module analog_output_channel_supervisor_bench import aocs_pkg::*;;
	logic clk_sys, rst_n, supplyShort, irq; // clock, reset, short detect, interrupt
	logic [31:0] rdata;
	logic [NUM_CH*16-1:0] chanOut;
	logic [1:0] dataFormat;
	logic [NUM_CH*3-1:0] chanRange;
	aocs_bus_type bus;
	int error_cnt = 0;
	int tests_run = 0;
	aocs_supervisor aocs_supervisor_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
		.supplyShort(supplyShort), .rdata(rdata), .irq(irq), .chanOut(chanOut),
		.dataFormat(dataFormat), .chanRange(chanRange));
	aocs_plc_model aocs_plc_model_inst (.clk_sys(clk_sys), .rdata(rdata), .bus(bus));
	////////////////////////////////////////////////////////////////
	// short forms of the controller's bus cycles
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		aocs_plc_model_inst.wr(a, d);
	endtask
	task automatic r(input logic [7:0] a, output logic [31:0] d);
		aocs_plc_model_inst.rd(a, d);
	endtask
	function automatic logic [7:0] ca(input int n, input logic [4:0] off);
		return CH_BASE + 8'(n * CH_STRIDE) + 8'(off);
	endfunction
	task automatic end_sim();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// defaults after reset, and an unmapped address reading zero
	task automatic t_reset();
		logic [31:0] d;
		`CHK(chanRange, 12'h000)
		`CHK(dataFormat, 2'h0)
		r(ca(0, CH_HIGH), d);
		`CHK(d, 32'h0000_03E8)
		r(ca(0, CH_LOW), d);
		`CHK(d, 32'h0000_0000)
		r(REG_UNIT_CTRL, d);
		`CHK(d, 32'h0000_0001)
		r(ca(1, CH_CTRL), d);
		`CHK(d, 32'h0000_0000)
		r(8'hFC, d);
		`CHK(d, 32'h0000_0000)
	endtask
	// every range code, an illegal code, every data format
	task automatic t_modes();
		for (int i = 0; i < 5; i++) begin
			w(ca(1, CH_CTRL), 32'(i));
			`CHK(chanRange[5:3], 3'(i))
		end
		// range changes leave the default bounds, which suit every range
		w(ca(1, CH_CTRL), 32'h5);
		`CHK(chanRange[5:3], 3'h4)
		for (int f = 0; f < 4; f++) begin
			w(REG_UNIT_CTRL, 32'(f * 2 + 1));
			`CHK(dataFormat, 2'(f))
		end
		w(REG_UNIT_CTRL, 32'h1);
	endtask
	// limit errors at the bound edges, sticky status, mask, clear, saturation
	task automatic t_limits();
		logic [31:0] d;
		w(REG_IRQ_MASK, 32'h1);
		w(ca(0, CH_CTRL), 32'h18);
		w(ca(0, CH_VALUE), 32'h3E9);
		r(REG_DIAG, d);
		`CHK(d, 32'h0000_0001)
		`CHK(irq, 1'b1)
		w(ca(0, CH_VALUE), 32'h3E8);
		r(REG_DIAG, d);
		`CHK(d, 32'h0000_0000)
		`CHK(irq, 1'b1)
		w(REG_IRQ_STAT, 32'h1);
		`CHK(irq, 1'b0)
		w(ca(0, CH_VALUE), 32'hFFFF_FFFF);
		r(REG_DIAG, d);
		`CHK(d, 32'h0000_0010)
		`CHK(irq, 1'b0)
		r(REG_IRQ_STAT, d);
		`CHK(d, 32'h0000_0010)
		w(ca(0, CH_HIGH), 32'h8000);
		r(ca(0, CH_HIGH), d);
		`CHK(d, 32'hFFFF_8002)
		w(ca(0, CH_LOW), 32'h8000);
		r(ca(0, CH_LOW), d);
		`CHK(d, 32'hFFFF_8001)
		w(ca(0, CH_CTRL), 32'h0);
	endtask
	// fault and idle substitution under terminal priority, fault hold with and without it
	task automatic t_subst();
		logic [31:0] d;
		w(ca(2, CH_FAULT), 32'h12C);
		w(ca(2, CH_IDLE), 32'hC8);
		w(ca(2, CH_CTRL), 32'h60);
		w(ca(2, CH_VALUE), 32'h1F4);
		w(ca(3, CH_VALUE), 32'h1F4);
		w(REG_COMM, 32'h1);
		`CHK(chanOut[32+:16], 16'h01F4)
		w(REG_UNIT_CTRL, 32'h9);
		`CHK(chanOut[32+:16], 16'h012C)
		w(REG_COMM, 32'h2);
		`CHK(chanOut[32+:16], 16'h00C8)
		w(REG_COMM, 32'h3);
		`CHK(chanOut[32+:16], 16'h012C)
		r(REG_COMM, d);
		`CHK(d, 32'h0000_0003)
		r(ca(2, CH_OUT), d);
		`CHK(d, 32'h0000_012C)
		w(ca(3, CH_VALUE), 32'h64);
		`CHK(chanOut[48+:16], 16'h01F4)
		w(REG_COMM, 32'h0);
		`CHK(chanOut[48+:16], 16'h0064)
		`CHK(chanOut[32+:16], 16'h01F4)
	endtask
	// supply short with monitoring on, then with it switched off
	task automatic t_short();
		logic [31:0] d;
		w(REG_IRQ_MASK, 32'h100);
		supplyShort <= 1'b1;
		r(REG_DIAG, d);
		r(REG_DIAG, d);
		`CHK(d, 32'h0000_0100)
		`CHK(irq, 1'b1)
		w(REG_UNIT_CTRL, 32'h0);
		r(REG_DIAG, d);
		`CHK(d, 32'h0000_0000)
		supplyShort <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// a hang ends the run as a mismatch
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		end_sim();
	end
	// reset for two cycles, then the scenarios
	initial begin
		rst_n = 1'b0;
		supplyShort = 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		t_reset();
		t_modes();
		t_limits();
		t_subst();
		t_short();
		end_sim();
	end
endmodule
`default_nettype wire
